// [logic/irq_cfg_defs.svh]
// Register offsets, field positions and reset values of the interrupt enable and priority block.
`ifndef IRQ_CFG_DEFS_SVH
`define IRQ_CFG_DEFS_SVH
`define OFS_ENABLE_3     8'h00
`define OFS_ENABLE_4     8'h04
`define OFS_PRIO_0       8'h08
`define OFS_PRIO_1       8'h0C
`define OFS_PRIO_2       8'h10
`define OFS_PRIO_3       8'h14
`define OFS_REQ_STATUS   8'h18
`define EN3_MASK         16'h21FF
`define EN4_MASK         16'h00F6
`define PRIO_FULL_MASK   16'h7777
`define PRIO3_MASK       16'h0777
`define EN_RESET         16'h0000
`define PRIO_RESET       16'h4444
`define FIELD_W          3
`define FIELD_STRIDE     4
`define LEVEL_OFF        3'h0
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// [logic/irq_cfg_pkg.sv]
// Types shared by the interrupt enable and priority block.
`default_nettype none
package irq_cfg_pkg;
   typedef logic [2:0] level_t;
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_RESP = 2'b01
   } rd_state_t;
endpackage
`default_nettype wire

// [logic/interrupt_enable_priority_regs.sv]
// Interrupt enable registers 3 and 4, priority registers 0 to 3, AXI4-Lite slave and request gating.
//
// Overview of operation
// - A set enable bit passes its source request; a cleared bit blocks it.
// - Both enable registers are readable, writable and reset to zero.
// - Priority code 111 means level 7, the highest level.
// - Codes 001 upward map straight to levels 1 through 7.
// - Priority code 000 disables the source whatever its enable bit says.
// - Unimplemented bits read zero and ignore writes.
// - Each priority field resets to 100, level 4.
// - Enable register 3 holds bits 13, 8 and 7 down to 0 as listed.
// - Enable register 4 holds bits 7 to 4, 2 and 1; others unimplemented.
// - Priority register 0 holds timer1, ocmp1, icap1, ext_irq0 fields.
// - Priority register 1 holds timer2, ocmp2, icap2, dma_ch0 fields.
// - Priority register 2 holds uart1_rx, spi1_event, spi1_err, timer3 fields.
// - Priority register 3 holds dma_ch1, adc1_done, uart1_tx; bits 15-11 unimplemented.
`include "irq_cfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module interrupt_enable_priority_regs
   import irq_cfg_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [15:0]       en3Flags,
   input  wire logic [15:0]       en4Flags,
   input  wire logic [15:0]       prioFlags,
   output logic [15:0]            en3Req,
   output logic [15:0]            en4Req,
   output logic [15:0]            prioReq,
   output logic [47:0]            prioReqLevel
);

   // ************************************************************
   // Helper functions
   // ************************************************************

   // Merges written bytes under the strobes and keeps only implemented bits.
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] st, input logic [15:0] msk);
      logic [15:0] v;
      v = old;
      if (st[0]) begin
         v[7:0] = wd[7:0];
      end
      if (st[1]) begin
         v[15:8] = wd[15:8];
      end
      return v & msk;
   endfunction

   function automatic level_t field(input logic [15:0] r, input int idx);
      return r[idx*`FIELD_STRIDE +: `FIELD_W];
   endfunction

   // ************************************************************
   // Write channel
   // ************************************************************

   logic              awHeld_reg;
   logic              wHeld_reg;
   logic [ADDR_W-1:0] awAddr_reg;
   logic [31:0]       wData_reg;
   logic [3:0]        wStrb_reg;
   logic              bValid_reg;
   logic [1:0]        bResp_reg;
   logic              doWrite;
   logic [15:0]       en3_reg;
   logic [15:0]       en4_reg;
   logic [15:0]       prio0_reg;
   logic [15:0]       prio1_reg;
   logic [15:0]       prio2_reg;
   logic [15:0]       prio3_reg;

   // Address and data are latched separately, so either may arrive first.
   assign s_axi_awready = !awHeld_reg && !bValid_reg;
   assign s_axi_wready  = !wHeld_reg && !bValid_reg;
   assign s_axi_bvalid  = bValid_reg;
   assign s_axi_bresp   = bResp_reg;
   assign doWrite       = awHeld_reg && wHeld_reg && !bValid_reg;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld_reg <= 1'b0;
         awAddr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_reg <= 1'b1;
         awAddr_reg <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wHeld_reg <= 1'b0;
         wData_reg <= '0;
         wStrb_reg <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_reg <= 1'b1;
         wData_reg <= s_axi_wdata;
         wStrb_reg <= s_axi_wstrb;
      end else if (doWrite) begin
         wHeld_reg <= 1'b0;
      end
   end

   // An unmapped offset answers with an error response and touches no register.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bValid_reg <= 1'b0;
         bResp_reg  <= `RESP_OKAY;
      end else if (doWrite) begin
         bValid_reg <= 1'b1;
         case (awAddr_reg)
            `OFS_ENABLE_3, `OFS_ENABLE_4, `OFS_PRIO_0, `OFS_PRIO_1,
            `OFS_PRIO_2, `OFS_PRIO_3, `OFS_REQ_STATUS: begin
               bResp_reg <= `RESP_OKAY;
            end
            default: begin
               bResp_reg <= `RESP_SLVERR;
            end
         endcase
      end else if (s_axi_bready) begin
         bValid_reg <= 1'b0;
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         en3_reg <= `EN_RESET;
         en4_reg <= `EN_RESET;
      end else if (doWrite && awAddr_reg == `OFS_ENABLE_3) begin
         en3_reg <= merge(en3_reg, wData_reg, wStrb_reg, `EN3_MASK);
      end else if (doWrite && awAddr_reg == `OFS_ENABLE_4) begin
         en4_reg <= merge(en4_reg, wData_reg, wStrb_reg, `EN4_MASK);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prio0_reg <= `PRIO_RESET;
         prio1_reg <= `PRIO_RESET;
         prio2_reg <= `PRIO_RESET;
         prio3_reg <= `PRIO_RESET & `PRIO3_MASK;
      end else if (doWrite) begin
         case (awAddr_reg)
            `OFS_PRIO_0: begin
               prio0_reg <= merge(prio0_reg, wData_reg, wStrb_reg, `PRIO_FULL_MASK);
            end
            `OFS_PRIO_1: begin
               prio1_reg <= merge(prio1_reg, wData_reg, wStrb_reg, `PRIO_FULL_MASK);
            end
            `OFS_PRIO_2: begin
               prio2_reg <= merge(prio2_reg, wData_reg, wStrb_reg, `PRIO_FULL_MASK);
            end
            `OFS_PRIO_3: begin
               prio3_reg <= merge(prio3_reg, wData_reg, wStrb_reg, `PRIO3_MASK);
            end
            default: begin
            end
         endcase
      end
   end

   // ************************************************************
   // Request gating
   // ************************************************************

   // Enable-register sources have their priority fields elsewhere, so only the enable gates them here.
   assign en3Req = en3Flags & en3_reg;
   assign en4Req = en4Flags & en4_reg;

   logic [15:0] reqLive;

   always_comb begin
      logic [63:0] prioCat;
      prioCat = {prio3_reg, prio2_reg, prio1_reg, prio0_reg};
      reqLive = '0;
      prioReqLevel = '0;
      for (int i = 0; i < 16; i++) begin
         if (prioFlags[i] && field(prioCat[i/4*16 +: 16], i % 4) != `LEVEL_OFF) begin
            reqLive[i] = 1'b1;
            prioReqLevel[i*3 +: 3] = field(prioCat[i/4*16 +: 16], i % 4);
         end
      end
   end
   assign prioReq = reqLive;

   // ************************************************************
   // Read channel
   // ************************************************************

   // Read data is registered, so it stands unchanged while rvalid waits for rready.
   rd_state_t   rdState_reg;
   logic [31:0] rData_reg;
   logic [1:0]  rResp_reg;

   assign s_axi_arready = (rdState_reg == RD_IDLE);
   assign s_axi_rvalid  = (rdState_reg == RD_RESP);
   assign s_axi_rdata   = rData_reg;
   assign s_axi_rresp   = rResp_reg;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdState_reg <= RD_IDLE;
         rData_reg   <= '0;
         rResp_reg   <= `RESP_OKAY;
      end else begin
         case (rdState_reg)
            RD_IDLE: begin
               if (s_axi_arvalid) begin
                  rdState_reg <= RD_RESP;
                  rResp_reg   <= `RESP_OKAY;
                  case (s_axi_araddr)
                     `OFS_ENABLE_3:   rData_reg <= {16'h0000, en3_reg};
                     `OFS_ENABLE_4:   rData_reg <= {16'h0000, en4_reg};
                     `OFS_PRIO_0:     rData_reg <= {16'h0000, prio0_reg};
                     `OFS_PRIO_1:     rData_reg <= {16'h0000, prio1_reg};
                     `OFS_PRIO_2:     rData_reg <= {16'h0000, prio2_reg};
                     `OFS_PRIO_3:     rData_reg <= {16'h0000, prio3_reg};
                     `OFS_REQ_STATUS: rData_reg <= {16'h0000, prioReq};
                     default: begin
                        rData_reg <= '0;
                        rResp_reg <= `RESP_SLVERR;
                     end
                  endcase
               end
            end
            RD_RESP: begin
               if (s_axi_rready) begin
                  rdState_reg <= RD_IDLE;
               end
            end
            default: begin
               rdState_reg <= RD_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************

   a_en_gate_pass: assert property (@(posedge ref_clk) disable iff (!rst_n)
      en3Req == (en3Flags & en3_reg) && en4Req == (en4Flags & en4_reg))
      else $error("Enable gating mismatch.");

   a_en_reset_zero: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> en3_reg == 16'h0000 && en4_reg == 16'h0000)
      else $error("Enable registers not clear after reset.");

   a_prio_reset_four: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> prio0_reg == 16'h4444 && prio3_reg == 16'h0444)
      else $error("Priority fields not at level four after reset.");

   a_level_seven_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (prioFlags[0] && prio0_reg[2:0] == 3'h7) |-> prioReq[0] && prioReqLevel[2:0] == 3'h7)
      else $error("Code 111 not presented as level seven.");

   a_level_one_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (prioFlags[4] && prio1_reg[2:0] == 3'h1) |-> prioReq[4] && prioReqLevel[14:12] == 3'h1)
      else $error("Code 001 not presented as level one.");

   a_zero_disables: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (prio2_reg[14:12] == 3'h0) |-> !prioReq[11] && prioReqLevel[35:33] == 3'h0)
      else $error("Disabled source still requests.");

   a_unimpl_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (en3_reg & ~16'h21FF) == 16'h0000 && (en4_reg & ~16'h00F6) == 16'h0000
      && (prio0_reg & 16'h8888) == 16'h0000 && prio3_reg[15:11] == 5'h00
      && (prio1_reg & 16'h8888) == 16'h0000 && (prio2_reg & 16'h8888) == 16'h0000)
      else $error("Unimplemented bit holds a one.");

   a_en3_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (doWrite && awAddr_reg == 8'h00 && wStrb_reg == 4'hF) |=> en3_reg == ($past(wData_reg[15:0]) & 16'h21FF))
      else $error("Enable register 3 write lost.");

   a_en4_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (doWrite && awAddr_reg == `OFS_ENABLE_4 && wStrb_reg == 4'hF)
      |=> en4_reg == ($past(wData_reg[15:0]) & `EN4_MASK))
      else $error("Enable register 4 write lost.");

   a_prio0_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (doWrite && awAddr_reg == `OFS_PRIO_0 && wStrb_reg == 4'hF)
      |=> prio0_reg == ($past(wData_reg[15:0]) & `PRIO_FULL_MASK))
      else $error("Priority register 0 write lost.");

   a_prio1_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (doWrite && awAddr_reg == `OFS_PRIO_1 && wStrb_reg == 4'hF)
      |=> prio1_reg == ($past(wData_reg[15:0]) & `PRIO_FULL_MASK))
      else $error("Priority register 1 write lost.");

   a_prio2_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (doWrite && awAddr_reg == `OFS_PRIO_2 && wStrb_reg == 4'hF)
      |=> prio2_reg == ($past(wData_reg[15:0]) & `PRIO_FULL_MASK))
      else $error("Priority register 2 write lost.");

   a_prio3_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (doWrite && awAddr_reg == 8'h14 && wStrb_reg == 4'hF) |=> prio3_reg == ($past(wData_reg[15:0]) & 16'h0777))
      else $error("Priority register 3 write lost.");

   a_write_resp: assert property (@(posedge ref_clk) disable iff (!rst_n)
      doWrite |=> s_axi_bvalid)
      else $error("Write response missing.");

   a_bad_write_resp: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (doWrite && awAddr_reg > `OFS_REQ_STATUS) |=> s_axi_bresp == `RESP_SLVERR)
      else $error("Unmapped write not refused.");

   a_read_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
      else $error("Read response missing.");

   a_read_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_REQ_STATUS)
      |=> s_axi_rdata == {16'h0000, $past(prioReq)})
      else $error("Request status read wrong.");

   c_write_done: cover property (@(posedge ref_clk) disable iff (!rst_n) s_axi_bvalid && s_axi_bready);
   c_read_done: cover property (@(posedge ref_clk) disable iff (!rst_n) s_axi_rvalid && s_axi_rready);
   c_req_seven: cover property (@(posedge ref_clk) disable iff (!rst_n) prioReq[0] && prioReqLevel[2:0] == 3'h7);
   c_bad_addr: cover property (@(posedge ref_clk) disable iff (!rst_n) s_axi_rvalid && s_axi_rresp == 2'h2);
   c_all_live: cover property (@(posedge ref_clk) disable iff (!rst_n) prioReq == 16'h7FFF);

endmodule // interrupt_enable_priority_regs
`default_nettype wire

// [tb/flag_source_model.sv]
// Behavioural model of the peripherals that raise interrupt flags.
`timescale 1ns/1ps
`default_nettype none
module flag_source_model (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        loadFlags,
   input  wire logic [47:0] newFlags,
   output logic [15:0]      en3Flags,
   output logic [15:0]      en4Flags,
   output logic [15:0]      prioFlags
);
   // Flags are held levels, so a request stays up until its source drops it.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {en3Flags, en4Flags, prioFlags} <= 48'h0;
      end else if (loadFlags) begin
         {en3Flags, en4Flags, prioFlags} <= newFlags;
      end
   end
endmodule // flag_source_model
`default_nettype wire

// [tb/interrupt_enable_priority_regs_test.sv]
// Self-checking bench for the interrupt enable and priority block.
`include "irq_cfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_priority_regs_test;
   logic        ref_clk, rst_n, loadFlags, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [15:0] en3Flags, en4Flags, prioFlags, en3Req, en4Req, prioReq;
   logic [47:0] prioReqLevel, newFlags;
   logic [31:0] d;
   int          errTotal = 0;
   int          testsRun = 0;
   logic [7:0]  ofs [6] = '{`OFS_ENABLE_3, `OFS_ENABLE_4, `OFS_PRIO_0, `OFS_PRIO_1, `OFS_PRIO_2, `OFS_PRIO_3};
   logic [15:0] rstVal [6] = '{16'h0000, 16'h0000, 16'h4444, 16'h4444, 16'h4444, 16'h0444};
   logic [15:0] mask [6] = '{16'h21FF, 16'h00F6, 16'h7777, 16'h7777, 16'h7777, 16'h0777};

   interrupt_enable_priority_regs interrupt_enable_priority_regs_inst (.ref_clk, .rst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .en3Flags, .en4Flags, .prioFlags, .en3Req, .en4Req, .prioReq, .prioReqLevel);
   flag_source_model flag_source_model_inst (.ref_clk, .rst_n, .loadFlags, .newFlags, .en3Flags, .en4Flags,
      .prioFlags);

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      testsRun++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         errTotal++;
      end
   endtask

   // Ready is sampled at the falling edge, so the handshake edge is the next rising one.
   task axiWrite(input logic [7:0] a, input logic [15:0] v, output logic [1:0] rsp);
      bit pa, pw, ta, tw;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {16'hFFFF, v};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      pa = 1;
      pw = 1;
      while (pa || pw) begin
         @(negedge ref_clk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         @(posedge ref_clk);
         if (pa && ta) begin
            s_axi_awvalid <= 1'b0;
            pa = 0;
         end
         if (pw && tw) begin
            s_axi_wvalid <= 1'b0;
            pw = 0;
         end
      end
      do begin
         @(negedge ref_clk);
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      @(posedge ref_clk);
      s_axi_bready <= 1'b0;
   endtask

   // Only the watchdog ends a wait; the master assumes no answer time.
   task axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge ref_clk);
      end while (s_axi_arready !== 1'b1);
      @(posedge ref_clk);
      s_axi_arvalid <= 1'b0;
      do begin
         @(negedge ref_clk);
      end while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge ref_clk);
      s_axi_rready <= 1'b0;
   endtask

   task setFlags(input logic [47:0] f);
      @(posedge ref_clk);
      newFlags <= f;
      loadFlags <= 1'b1;
      @(posedge ref_clk);
      loadFlags <= 1'b0;
      @(negedge ref_clk);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task testReset;
      for (int i = 0; i < 6; i++) begin
         axiRead(ofs[i], d, r);
         chk("reset value", {32'h0, rstVal[i]}, d);
      end
   endtask

   task testMasks;
      for (int i = 0; i < 6; i++) begin
         axiWrite(ofs[i], 16'hFFFF, r);
         chk("write resp", `RESP_OKAY, r);
         axiRead(ofs[i], d, r);
         chk("set bits", {32'h0, mask[i]}, d);
         axiWrite(ofs[i], 16'h0000, r);
         axiRead(ofs[i], d, r);
         chk("cleared", 48'h0, d);
      end
   endtask

   task testGating;
      setFlags({48{1'b1}});
      chk("blocked en3", 48'h0, en3Req);
      chk("code zero", 48'h0, prioReqLevel);
      chk("code zero req", 48'h0, prioReq);
      axiWrite(ofs[0], 16'hFFFF, r);
      axiWrite(ofs[1], 16'hFFFF, r);
      @(negedge ref_clk);
      chk("en3 req", 48'h21FF, en3Req);
      chk("en4 req", 48'h00F6, en4Req);
      setFlags({16'h0, 16'h0, 16'hFFFF});
      chk("no flag", 48'h0, {en3Req, en4Req});
   endtask

   task testLevels;
      setFlags({48{1'b1}});
      for (int c = 0; c < 8; c++) begin
         axiWrite(ofs[2], {4{1'b0, c[2:0]}}, r);
         @(negedge ref_clk);
         chk("level", (c == 0) ? 12'h0 : {4{c[2:0]}}, prioReqLevel[11:0]);
         chk("req", (c == 0) ? 4'h0 : 4'hF, prioReq[3:0]);
      end
      for (int k = 0; k < 4; k++) begin
         axiWrite(ofs[k + 2], 16'h4321, r);
         @(negedge ref_clk);
         chk("field map", (k == 3) ? 12'h0D1 : 12'h8D1, prioReqLevel[12*k +: 12]);
         chk("map req", (k == 3) ? 4'h7 : 4'hF, prioReq[4*k +: 4]);
      end
      axiRead(`OFS_REQ_STATUS, d, r);
      chk("request status", 48'h7FFF, d);
      setFlags(48'h0);
      chk("flag off", 48'h0, {prioReq, prioReqLevel[31:0]});
   endtask

   task testStrobes;
      @(posedge ref_clk);
      s_axi_wstrb <= 4'h2;
      axiWrite(ofs[2], 16'h0000, r);
      axiRead(ofs[2], d, r);
      chk("strobe high byte", 48'h0021, d);
      @(posedge ref_clk);
      s_axi_wstrb <= 4'hF;
   endtask

   task testUnmapped;
      axiWrite(8'h1C, 16'hFFFF, r);
      chk("bad write", `RESP_SLVERR, r);
      axiRead(8'h1C, d, r);
      chk("bad read", {`RESP_SLVERR, 32'h0}, {r, d});
   endtask

   task print_verdict;
      $display("Comparisons %0d, mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // The whole sequence takes a few hundred cycles; the limit leaves ample margin.
   initial begin
      #400000;
      errTotal++;
      print_verdict;
   end

   initial begin
      {rst_n, loadFlags, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      newFlags = 48'h0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      testReset();
      testMasks();
      testGating();
      testLevels();
      testStrobes();
      testUnmapped();
      print_verdict;
   end
endmodule // interrupt_enable_priority_regs_test
`default_nettype wire
